// *** inc/dtimer_pkg.sv ***
// Constants and types shared by the discard timer control block
package dtimer_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_CLR_OFS = 8'h08;
	localparam logic [7:0] IRQ_EN_OFS = 8'h0C;
	localparam logic [7:0] TMR_STATE_OFS = 8'h10;

	// Control/status field positions
	localparam int PRI_SEL_BIT = 24;
	localparam int SEC_SEL_BIT = 25;
	localparam int TMO_STAT_BIT = 26;
	localparam int SERR_EN_BIT = 27;
	localparam int RSVD_LSB = 28;
	localparam int RSVD_MSB = 31;

	// Interrupt register field positions
	localparam int IRQ_PRI_BIT = 0;
	localparam int IRQ_SEC_BIT = 1;

	// Reset values
	localparam logic SEL_RST = 1'b0;
	localparam logic TMO_STAT_RST = 1'b0;
	localparam logic SERR_EN_RST = 1'b0;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// Clock period, timer lengths in clock cycles and counter width
	localparam int CLK_PERIOD_NS = 50;
	localparam int DT_LONG_EXP = 15;
	localparam int DT_SHORT_EXP = 10;
	localparam int DT_LONG_CYCLES = 1 << DT_LONG_EXP;
	localparam int DT_SHORT_CYCLES = 1 << DT_SHORT_EXP;
	localparam int DT_CNT_W = 15;

	typedef enum logic [1:0] {
		DT_IDLE = 2'b00,
		DT_RUN = 2'b01
	} dt_state_t;

endpackage

// *** inc/dtimer_if.sv ***
// Link between the control block and one discard timer
`timescale 1ns/1ps
interface dtimer_if;
	logic start;
	logic stop;
	logic sel_short;
	logic sel_lat;
	logic running;
	logic expire;

	modport ctrl (output start, output stop, output sel_short,
		input sel_lat, input running, input expire);
	modport timer (input start, input stop, input sel_short,
		output sel_lat, output running, output expire);
endinterface

// *** verilog/discard_timer_unit.sv ***
// One delayed-transaction discard timer
`timescale 1ns/1ps
module discard_timer_unit
	import dtimer_pkg::*;
#(
	parameter int LONG_CYCLES = DT_LONG_CYCLES,
	parameter int SHORT_CYCLES = DT_SHORT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	dtimer_if.timer dt
);
	localparam logic [DT_CNT_W-1:0] LONG_LAST = DT_CNT_W'(LONG_CYCLES - 1);
	localparam logic [DT_CNT_W-1:0] SHORT_LAST = DT_CNT_W'(SHORT_CYCLES - 1);

	dt_state_t state_ff, nxt_state;
	logic [DT_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic sel_ff, nxt_sel;
	logic exp_ff, nxt_exp;
	logic [DT_CNT_W-1:0] last;

	// Length is latched at start so a select change never bends a running count
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sel = sel_ff;
		nxt_exp = 1'b0;
		last = sel_ff ? SHORT_LAST : LONG_LAST;
		case (state_ff)
			DT_IDLE: begin
				if (dt.start && !dt.stop) begin
					nxt_state = DT_RUN;
					nxt_cnt = '0;
					nxt_sel = dt.sel_short;
				end
			end
			DT_RUN: begin
				// Retry arriving on the last cycle still beats expiry
				if (dt.stop) begin
					nxt_state = DT_IDLE;
				end else if (cnt_ff == last) begin
					nxt_state = DT_IDLE;
					nxt_exp = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + DT_CNT_W'(1);
				end
			end
			default: begin
				nxt_state = DT_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff <= DT_IDLE;
			cnt_ff <= '0;
			sel_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sel_ff <= nxt_sel;
			exp_ff <= nxt_exp;
		end
	end

	assign dt.sel_lat = sel_ff;
	assign dt.running = (state_ff == DT_RUN);
	assign dt.expire = exp_ff;
endmodule

// *** verilog/bridge_discard_timer_ctrl.sv ***
// Discard timer control/status with Wishbone registers and error pin
`timescale 1ns/1ps
// Functional notes
// - Secondary timer: select 0 long, 1 short
// - Either timer expiry sets timeout status
// - Enabled: expiry drives primary system error
// - Disabled: expiry never drives error pin
// - Upper four bits read zero always
// - Primary timer: select 0 long, 1 short
module bridge_discard_timer_ctrl
	import dtimer_pkg::*;
#(
	parameter int LONG_CYCLES = DT_LONG_CYCLES
) (
	input wire logic I_SYS_CLK,
	input wire logic I_ARST_N,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire logic I_PRI_REQ_QUEUED,
	input wire logic I_PRI_REQ_DONE,
	input wire logic I_SEC_REQ_QUEUED,
	input wire logic I_SEC_REQ_DONE,
	output logic O_PRI_DISCARD,
	output logic O_SEC_DISCARD,
	output logic O_PRIMARY_SYSTEM_ERROR_PIN_OUT,
	output logic O_PRIMARY_SYSTEM_ERROR_PIN_OE,
	output logic O_IRQ
);
	dtimer_if pri_dt ();
	dtimer_if sec_dt ();

	logic ack_ff, nxt_ack;
	logic [31:0] dat_ff, nxt_dat;
	logic pri_sel_ff, nxt_pri_sel;
	logic sec_sel_ff, nxt_sec_sel;
	logic tmo_ff, nxt_tmo;
	logic serr_en_ff, nxt_serr_en;
	logic serr_oe_ff, nxt_serr_oe;
	logic [1:0] irq_stat_ff, nxt_irq_stat;
	logic [1:0] irq_en_ff, nxt_irq_en;
	logic req;
	logic wr_acc;
	logic any_exp;
	logic [31:0] rd_word;

	////////////////////////////////////////////////////////////////////////////
	// Timers

	assign pri_dt.start = I_PRI_REQ_QUEUED;
	assign pri_dt.stop = I_PRI_REQ_DONE;
	assign pri_dt.sel_short = pri_sel_ff;
	assign sec_dt.start = I_SEC_REQ_QUEUED;
	assign sec_dt.stop = I_SEC_REQ_DONE;
	assign sec_dt.sel_short = sec_sel_ff;

	discard_timer_unit #(
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(DT_SHORT_CYCLES)
	) u_pri_timer (
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.dt(pri_dt.timer)
	);

	discard_timer_unit #(
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(DT_SHORT_CYCLES)
	) u_sec_timer (
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.dt(sec_dt.timer)
	);

	assign any_exp = pri_dt.expire | sec_dt.expire;

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave and registers

	assign req = I_WB_CYC & I_WB_STB;
	// Writes land on the edge where the master sees ack
	assign wr_acc = req & I_WB_WE & ack_ff;

	always_comb begin
		rd_word = 32'h0000_0000;
		case ({I_WB_ADR[7:2], 2'b00})
			CTRL_OFS: begin
				rd_word[PRI_SEL_BIT] = pri_sel_ff;
				rd_word[SEC_SEL_BIT] = sec_sel_ff;
				rd_word[TMO_STAT_BIT] = tmo_ff;
				rd_word[SERR_EN_BIT] = serr_en_ff;
				rd_word[RSVD_MSB:RSVD_LSB] = 4'h0;
			end
			IRQ_STAT_OFS: rd_word[1:0] = irq_stat_ff;
			IRQ_EN_OFS: rd_word[1:0] = irq_en_ff;
			TMR_STATE_OFS: begin
				rd_word[IRQ_PRI_BIT] = pri_dt.running;
				rd_word[IRQ_SEC_BIT] = sec_dt.running;
			end
			// Clear register and unmapped words read zero and ack normally
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_comb begin
		nxt_ack = req & ~ack_ff;
		nxt_dat = (req & ~ack_ff) ? rd_word : dat_ff;
		nxt_pri_sel = pri_sel_ff;
		nxt_sec_sel = sec_sel_ff;
		nxt_serr_en = serr_en_ff;
		nxt_tmo = tmo_ff;
		nxt_irq_en = irq_en_ff;
		nxt_irq_stat = irq_stat_ff;
		if (wr_acc && I_WB_ADR[7:2] == CTRL_OFS[7:2] && I_WB_SEL[3]) begin
			nxt_pri_sel = I_WB_DAT[PRI_SEL_BIT];
			nxt_sec_sel = I_WB_DAT[SEC_SEL_BIT];
			nxt_serr_en = I_WB_DAT[SERR_EN_BIT];
			if (I_WB_DAT[TMO_STAT_BIT]) begin
				nxt_tmo = 1'b0;
			end
		end
		if (wr_acc && I_WB_ADR[7:2] == IRQ_EN_OFS[7:2] && I_WB_SEL[0]) begin
			nxt_irq_en = I_WB_DAT[1:0];
		end
		if (wr_acc && I_WB_ADR[7:2] == IRQ_CLR_OFS[7:2] && I_WB_SEL[0]) begin
			nxt_irq_stat = irq_stat_ff & ~I_WB_DAT[1:0];
		end
		// Set placed last so a same-cycle expiry beats the clear
		if (any_exp) begin
			nxt_tmo = 1'b1;
		end
		nxt_irq_stat[IRQ_PRI_BIT] = nxt_irq_stat[IRQ_PRI_BIT] | pri_dt.expire;
		nxt_irq_stat[IRQ_SEC_BIT] = nxt_irq_stat[IRQ_SEC_BIT] | sec_dt.expire;
		// One-clock assertion per expiry, gated by the enable
		nxt_serr_oe = any_exp & serr_en_ff;
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
			pri_sel_ff <= SEL_RST;
			sec_sel_ff <= SEL_RST;
			tmo_ff <= TMO_STAT_RST;
			serr_en_ff <= SERR_EN_RST;
			serr_oe_ff <= 1'b0;
			irq_stat_ff <= IRQ_RST;
			irq_en_ff <= IRQ_RST;
		end else begin
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
			pri_sel_ff <= nxt_pri_sel;
			sec_sel_ff <= nxt_sec_sel;
			tmo_ff <= nxt_tmo;
			serr_en_ff <= nxt_serr_en;
			serr_oe_ff <= nxt_serr_oe;
			irq_stat_ff <= nxt_irq_stat;
			irq_en_ff <= nxt_irq_en;
		end
	end

	assign O_WB_ACK = ack_ff;
	assign O_WB_DAT = dat_ff;
	assign O_PRI_DISCARD = pri_dt.expire;
	assign O_SEC_DISCARD = sec_dt.expire;
	// Open-drain: only ever pulls low
	assign O_PRIMARY_SYSTEM_ERROR_PIN_OUT = 1'b0;
	assign O_PRIMARY_SYSTEM_ERROR_PIN_OE = serr_oe_ff;
	assign O_IRQ = |(irq_stat_ff & irq_en_ff);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Helper counts the expiry edge too, so it ends at the full length
	localparam logic [15:0] LONG_LEN16 = 16'(LONG_CYCLES);
	localparam logic [15:0] SHORT_LEN16 = 16'(DT_SHORT_CYCLES);
	logic [15:0] pri_hcnt_ff;
	logic [15:0] sec_hcnt_ff;

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pri_hcnt_ff <= 16'h0000;
			sec_hcnt_ff <= 16'h0000;
		end else begin
			pri_hcnt_ff <= pri_dt.running ? pri_hcnt_ff + 16'h0001 : 16'h0000;
			sec_hcnt_ff <= sec_dt.running ? sec_hcnt_ff + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	AST_PRI_LEN: assert property (
		$rose(pri_dt.expire) |->
			pri_hcnt_ff == (pri_dt.sel_lat ? SHORT_LEN16 : LONG_LEN16))
		else $error("primary discard timer length wrong");
	AST_SEC_LEN: assert property (
		$rose(sec_dt.expire) |->
			sec_hcnt_ff == (sec_dt.sel_lat ? SHORT_LEN16 : LONG_LEN16))
		else $error("secondary discard timer length wrong");
	AST_TMO_SET: assert property (
		(pri_dt.expire || sec_dt.expire) |=> tmo_ff)
		else $error("timeout status not set on expiry");
	AST_SERR_ON: assert property (
		(any_exp && serr_en_ff) |=> O_PRIMARY_SYSTEM_ERROR_PIN_OE
			&& !O_PRIMARY_SYSTEM_ERROR_PIN_OUT)
		else $error("error pin not asserted on enabled expiry");
	AST_SERR_OFF: assert property (
		!(any_exp && serr_en_ff) |=> !O_PRIMARY_SYSTEM_ERROR_PIN_OE)
		else $error("error pin asserted without enabled expiry");
	AST_RSVD_ZERO: assert property (
		(O_WB_ACK && !I_WB_WE && I_WB_ADR[7:2] == CTRL_OFS[7:2])
			|-> O_WB_DAT[RSVD_MSB:RSVD_LSB] == 4'h0)
		else $error("reserved bits read nonzero");
	AST_W1C_CLEAR: assert property (
		(wr_acc && I_WB_ADR[7:2] == CTRL_OFS[7:2] && I_WB_SEL[3]
			&& I_WB_DAT[TMO_STAT_BIT] && !any_exp) |=> !tmo_ff)
		else $error("write one did not clear timeout status");
	AST_W0_KEEP: assert property (
		(wr_acc && tmo_ff && !I_WB_DAT[TMO_STAT_BIT]) |=> tmo_ff)
		else $error("write zero changed timeout status");
endmodule

// *** testbench/pci_initiator_model.sv ***
// Far-side initiator: queues a delayed request, optionally retries later
`timescale 1ns/1ps
module pci_initiator_model (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_go,
	input wire logic [15:0] i_retry,
	output logic o_queued,
	output logic o_done
);
	logic [15:0] cnt_ff;
	logic armed_ff;
	// Retry of 0 means the initiator never comes back, so the timer must expire
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_queued <= 1'b0;
			o_done <= 1'b0;
			cnt_ff <= 16'h0;
			armed_ff <= 1'b0;
		end else begin
			o_queued <= i_go;
			o_done <= armed_ff && cnt_ff == 16'h1;
			if (i_go) begin
				armed_ff <= i_retry != 16'h0;
				cnt_ff <= i_retry;
			end else if (armed_ff) begin
				cnt_ff <= cnt_ff - 16'h1;
				armed_ff <= cnt_ff != 16'h1;
			end
		end
	end
endmodule

// *** testbench/bridge_discard_timer_ctrl_tb_top.sv ***
// Self-checking bench for the discard timer control block
`timescale 1ns/1ps
module bridge_discard_timer_ctrl_tb_top;
	import dtimer_pkg::*;
	// Short long-count keeps the run brief
	localparam int LONG = 64;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic go_p = 1'b0;
	logic go_s = 1'b0;
	logic [15:0] rt_p = 16'h0;
	logic [15:0] rt_s = 16'h0;
	logic q_p, d_p, q_s, d_s, ack, dis_p, dis_s, oe, irq, pin;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int k;
	bit o;

	always #25 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			errors++;
			stop_test();
		end
	end

	bridge_discard_timer_ctrl #(.LONG_CYCLES(LONG)) u_bridge_discard_timer_ctrl (
		.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_PRI_REQ_QUEUED(q_p), .I_PRI_REQ_DONE(d_p), .I_SEC_REQ_QUEUED(q_s),
		.I_SEC_REQ_DONE(d_s), .O_PRI_DISCARD(dis_p), .O_SEC_DISCARD(dis_s),
		.O_PRIMARY_SYSTEM_ERROR_PIN_OUT(pin), .O_PRIMARY_SYSTEM_ERROR_PIN_OE(oe), .O_IRQ(irq));
	pci_initiator_model u_pri_initiator (.i_clk(clk), .i_arst_n(rst_n), .i_go(go_p),
		.i_retry(rt_p), .o_queued(q_p), .o_done(d_p));
	pci_initiator_model u_sec_initiator (.i_clk(clk), .i_arst_n(rst_n), .i_go(go_s),
		.i_retry(rt_s), .o_queued(q_s), .o_done(d_s));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n == 50) errors++;
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// k = edges from start edge to discard; limit 1100 means none came
	task automatic expire(input bit sec, input logic [15:0] retry, output int k,
		output bit saw_oe);
		k = 0;
		saw_oe = 1'b0;
		@(posedge clk);
		if (sec) begin
			go_s <= 1'b1;
			rt_s <= retry;
		end else begin
			go_p <= 1'b1;
			rt_p <= retry;
		end
		@(posedge clk);
		go_s <= 1'b0;
		go_p <= 1'b0;
		@(posedge clk);
		do begin
			@(posedge clk);
			k++;
			@(negedge clk);
		end while ((sec ? dis_s : dis_p) !== 1'b1 && k < 1100);
		repeat (2) begin
			@(negedge clk);
			saw_oe |= oe;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic test_primary;
		wb(1'b1, IRQ_EN_OFS, 32'h1, 4'h1);
		wb(1'b0, IRQ_EN_OFS, 32'h0, 4'h0);
		check(rd, 32'h1);
		expire(1'b0, 16'h0, k, o);
		check(k, 32'(LONG));
		check(32'(o), 32'h0);
		check(32'(irq), 32'h1);
		wb(1'b0, CTRL_OFS, 32'h0, 4'h0);
		check(rd, 32'h0400_0000);
		wb(1'b1, CTRL_OFS, 32'h0, 4'h8);
		wb(1'b0, CTRL_OFS, 32'h0, 4'h0);
		check(rd, 32'h0400_0000);
		wb(1'b1, CTRL_OFS, 32'h0400_0000, 4'h8);
		wb(1'b0, CTRL_OFS, 32'h0, 4'h0);
		check(rd, 32'h0);
		wb(1'b1, IRQ_CLR_OFS, 32'h1, 4'h1);
		@(negedge clk);
		check(32'(irq), 32'h0);
		$display("test primary done");
	endtask

	task automatic test_secondary;
		wb(1'b1, CTRL_OFS, 32'hFA00_0000, 4'h8);
		wb(1'b0, CTRL_OFS, 32'h0, 4'h0);
		check(rd, 32'h0A00_0000);
		expire(1'b1, 16'h0, k, o);
		check(k, 32'd1024);
		check(32'(o), 32'h1);
		check(32'(pin), 32'h0);
		check(32'(irq), 32'h0);
		wb(1'b0, IRQ_STAT_OFS, 32'h0, 4'h0);
		check(rd, 32'h2);
		wb(1'b0, CTRL_OFS, 32'h0, 4'h0);
		check(rd, 32'h0E00_0000);
		$display("test secondary done");
	endtask

	// Short primary with error pin off, then a retry that aborts the timer
	task automatic test_abort;
		wb(1'b1, CTRL_OFS, 32'h0100_0000, 4'h8);
		expire(1'b0, 16'h0, k, o);
		check(k, 32'd1024);
		check(32'(o), 32'h0);
		expire(1'b0, 16'h000A, k, o);
		check(k, 32'd1100);
		wb(1'b0, TMR_STATE_OFS, 32'h0, 4'h0);
		check(rd, 32'h0);
		// Retry count of 10 is still set, so this run aborts by itself
		@(posedge clk);
		go_p <= 1'b1;
		@(posedge clk);
		go_p <= 1'b0;
		wb(1'b0, TMR_STATE_OFS, 32'h0, 4'h0);
		check(rd, 32'h1);
		$display("test abort done");
	endtask

	task automatic stop_test;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, CTRL_OFS, 32'h0, 4'h0);
		check(rd, 32'h0);
		wb(1'b0, 8'h3C, 32'h0, 4'h0);
		check(rd, 32'h0);
		test_primary();
		test_secondary();
		test_abort();
		stop_test();
	end
endmodule
